// ==== core/sensor_process_data_teach.sv ====
// Purpose: Teach button factory reset, LED patterns and cyclic process data
// Assumes: All inputs synchronous to sys_clk; master polls with pd_poll
// Notes:   Long times run on a 62.5 ms tick
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs.svh"

module sensor_process_data_teach #(
    parameter int TICK_CYCLES = `TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // Teach button and configuration
    input  wire logic                          teach_button,
    input  wire logic [15:0]                   btn_timeout_s,
    // Measurement
    input  wire sensor_pkg::meas_status_t      meas,
    input  wire logic signed [31:0]            field_near,
    input  wire logic signed [31:0]            field_far,
    // Factory restore handshake
    output logic                               factory_restore_req,
    input  wire logic                          factory_restore_done,
    input  wire logic                          factory_restore_fail,
    // Cyclic process data
    input  wire logic                          pd_poll,
    input  wire logic [`PD_OUT_W-1:0]          pd_out,
    output logic [`PD_IN_W-1:0]                pd_in,
    output logic                               pd_in_valid,
    // Acyclic parameters
    input  wire logic                          param_req,
    input  wire logic [7:0]                    param_index,
    input  wire logic [31:0]                   param_store_data,
    output logic [7:0]                         param_store_index,
    output logic                               param_ack,
    output logic [31:0]                        param_rdata,
    // Device outputs
    output sensor_pkg::led_t                   leds,
    output logic                               laser_enable,
    output logic                               locate_indicator_request,
    output logic [`ANALOG_W-1:0]               analog_code
);

    // ---------------------------------------------------------------
    // Time base
    // ---------------------------------------------------------------
    logic [22:0] tick_cnt_r, tick_cnt_nxt;
    logic [2:0]  phase_r, phase_nxt;
    logic        tick;
    logic        blink2, blink8;

    assign tick   = (tick_cnt_r == 23'(TICK_CYCLES - 1));
    assign blink8 = phase_r[0];
    assign blink2 = phase_r[2];

    always_comb begin
        tick_cnt_nxt = tick ? '0 : tick_cnt_r + 23'h00_0001;
        phase_nxt    = tick ? phase_r + 3'h1 : phase_r;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= '0;
            phase_r    <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            phase_r    <= phase_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Button timeout
    // ---------------------------------------------------------------
    // Only a reset re-enables the button, as a restart does
    logic [19:0] tmo_r, tmo_nxt;
    logic        btn_en_r, btn_en_nxt;
    logic [19:0] tmo_limit;

    assign tmo_limit = 20'(btn_timeout_s) * 20'(`TICKS_PER_S);

    always_comb begin
        tmo_nxt    = tmo_r;
        btn_en_nxt = btn_en_r;
        if (btn_en_r && tmo_limit != '0 && tick) begin
            tmo_nxt = tmo_r + 20'h0_0001;
            if (tmo_nxt >= tmo_limit) begin
                btn_en_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tmo_r    <= '0;
            btn_en_r <= 1'b1;
        end else begin
            tmo_r    <= tmo_nxt;
            btn_en_r <= btn_en_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Teach sequence
    // ---------------------------------------------------------------
    sensor_pkg::teach_state_t state_r, state_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic       btn_prev_r, btn_prev_nxt;

    always_comb begin
        state_nxt    = state_r;
        hold_nxt     = hold_r;
        btn_prev_nxt = teach_button;
        case (state_r)
            sensor_pkg::ST_IDLE: begin
                hold_nxt = '0;
                // Fresh press only, so a hold past the abort time stays out
                if (teach_button && !btn_prev_r && btn_en_r) begin
                    state_nxt = sensor_pkg::ST_ACTIVE;
                end
            end
            sensor_pkg::ST_ACTIVE: begin
                if (!teach_button) begin
                    state_nxt = sensor_pkg::ST_IDLE;
                end else if (tick) begin
                    hold_nxt = hold_r + 8'h01;
                    if (hold_nxt == 8'(`HOLD_RESET_TICKS)) begin
                        state_nxt = sensor_pkg::ST_SELECT;
                    end
                end
            end
            sensor_pkg::ST_SELECT: begin
                if (!teach_button) begin
                    state_nxt = sensor_pkg::ST_RESTORE;
                end else if (tick) begin
                    hold_nxt = hold_r + 8'h01;
                    if (hold_nxt == 8'(`HOLD_ABORT_TICKS)) begin
                        state_nxt = sensor_pkg::ST_IDLE;
                    end
                end
            end
            sensor_pkg::ST_RESTORE: begin
                hold_nxt = '0;
                if (factory_restore_fail) begin
                    state_nxt = sensor_pkg::ST_FAIL;
                end else if (factory_restore_done) begin
                    state_nxt = sensor_pkg::ST_OK;
                end
            end
            sensor_pkg::ST_OK, sensor_pkg::ST_FAIL: begin
                if (tick) begin
                    hold_nxt = hold_r + 8'h01;
                    if ((state_r == sensor_pkg::ST_OK && hold_nxt == 8'(`SHOW_OK_TICKS)) ||
                        (state_r == sensor_pkg::ST_FAIL && hold_nxt == 8'(`SHOW_FAIL_TICKS))) begin
                        state_nxt = sensor_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = sensor_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= sensor_pkg::ST_IDLE;
            hold_r     <= '0;
            btn_prev_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            hold_r     <= hold_nxt;
            btn_prev_r <= btn_prev_nxt;
        end
    end

    // Restore stays requested until the store answers
    assign factory_restore_req = (state_r == sensor_pkg::ST_RESTORE);

    // ---------------------------------------------------------------
    // Process data and parameters
    // ---------------------------------------------------------------
    logic [`PD_IN_W-1:0] pd_in_r, pd_in_nxt;
    logic                pd_valid_r, laser_r, laser_nxt, locate_r, locate_nxt;
    logic                pack_r, pack_nxt;
    logic [31:0]         prd_r, prd_nxt;
    sensor_pkg::led_t    leds_r, leds_nxt;

    always_comb begin
        pd_in_nxt  = pd_in_r;
        laser_nxt  = laser_r;
        locate_nxt = locate_r;
        if (pd_poll) begin
            pd_in_nxt = '0;
            pd_in_nxt[`PD_IN_W-1:`PD_DIST_LSB]           = meas.distance;
            pd_in_nxt[`PD_SCALE_LSB+7:`PD_SCALE_LSB]     = meas.scale;
            pd_in_nxt[`PD_ALARM_BIT]                     = meas.alarm;
            pd_in_nxt[`PD_QUALITY_BIT]                   = meas.quality_low;
            pd_in_nxt[`PD_SWITCH_BIT]                    = meas.switching_channel_one;
            laser_nxt  = pd_out[`PD_LASER_BIT];
            locate_nxt = pd_out[`PD_LOCATE_BIT];
        end
        pack_nxt = param_req;
        prd_nxt  = param_req ? param_store_data : prd_r;
    end

    // ---------------------------------------------------------------
    // LED patterns
    // ---------------------------------------------------------------
    // Teach display wins over locate, locate over normal status
    always_comb begin
        case (state_r)
            sensor_pkg::ST_ACTIVE, sensor_pkg::ST_OK: leds_nxt = '{1'b1, 1'b1};
            sensor_pkg::ST_SELECT: leds_nxt = '{blink2, blink2};
            sensor_pkg::ST_FAIL:   leds_nxt = '{blink8, blink8};
            default: begin
                if (locate_r) begin
                    leds_nxt = '{blink2, blink2};
                end else begin
                    leds_nxt = '{1'b1, meas.alarm};
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pd_in_r    <= '0;
            pd_valid_r <= 1'b0;
            laser_r    <= `LASER_RESET_VAL;
            locate_r   <= 1'b0;
            pack_r     <= 1'b0;
            prd_r      <= '0;
            leds_r     <= '0;
        end else begin
            pd_in_r    <= pd_in_nxt;
            pd_valid_r <= pd_poll;
            laser_r    <= laser_nxt;
            locate_r   <= locate_nxt;
            pack_r     <= pack_nxt;
            prd_r      <= prd_nxt;
            leds_r     <= leds_nxt;
        end
    end

    assign pd_in                    = pd_in_r;
    assign pd_in_valid              = pd_valid_r;
    assign param_store_index        = param_index;
    assign param_ack                = pack_r;
    assign param_rdata              = prd_r;
    assign leds                     = leds_r;
    assign laser_enable             = laser_r;
    assign locate_indicator_request = locate_r;

    analog_scaler u_analog (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .distance   (meas.distance),
        .field_near (field_near),
        .field_far  (field_far),
        .code       (analog_code)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_teach_leds;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == sensor_pkg::ST_ACTIVE |=> leds.green && leds.yellow;
    endproperty
    a_teach_leds: assert property (p_teach_leds) else $error("teach leds off");

    property p_select;
        @(posedge sys_clk) disable iff (!resetn)
        (state_r == sensor_pkg::ST_ACTIVE && teach_button && tick &&
         hold_r == 8'(`HOLD_RESET_TICKS - 1)) |=> state_r == sensor_pkg::ST_SELECT;
    endproperty
    a_select: assert property (p_select) else $error("reset not selected");

    property p_select_blink;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == sensor_pkg::ST_SELECT |=> leds.green == $past(blink2) && leds.yellow == leds.green;
    endproperty
    a_select_blink: assert property (p_select_blink) else $error("2 Hz pattern wrong");

    property p_ok;
        @(posedge sys_clk) disable iff (!resetn)
        (factory_restore_req && factory_restore_done && !factory_restore_fail)
        |=> state_r == sensor_pkg::ST_OK ##1 leds.green && leds.yellow;
    endproperty
    a_ok: assert property (p_ok) else $error("success display wrong");

    property p_fail;
        @(posedge sys_clk) disable iff (!resetn)
        state_r == sensor_pkg::ST_FAIL |=> leds.green == $past(blink8) && leds.yellow == leds.green;
    endproperty
    a_fail: assert property (p_fail) else $error("8 Hz pattern wrong");

    property p_locate;
        @(posedge sys_clk) disable iff (!resetn)
        (state_r == sensor_pkg::ST_IDLE && locate_r) |=> leds.green == $past(blink2)
                    && leds.yellow == leds.green;
    endproperty
    a_locate: assert property (p_locate) else $error("locate pattern wrong");

    property p_poll;
        @(posedge sys_clk) disable iff (!resetn)
        pd_poll |=> pd_in_valid && pd_in[`PD_IN_W-1:`PD_DIST_LSB] == $past(meas.distance)
                    && pd_in[`PD_SCALE_LSB+7:`PD_SCALE_LSB] == $past(meas.scale);
    endproperty
    a_poll: assert property (p_poll) else $error("process data not delivered");

    property p_status_bits;
        @(posedge sys_clk) disable iff (!resetn)
        pd_poll |=> pd_in[`PD_ALARM_BIT] == $past(meas.alarm)
                    && pd_in[`PD_QUALITY_BIT] == $past(meas.quality_low)
                    && pd_in[`PD_SWITCH_BIT] == $past(meas.switching_channel_one);
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits wrong");

    property p_unused_zero;
        @(posedge sys_clk) disable iff (!resetn)
        pd_in_valid |-> pd_in[7:4] == 4'h0 && !pd_in[1];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("spare bits set");

    property p_out_bits;
        @(posedge sys_clk) disable iff (!resetn)
        pd_poll |=> laser_enable == $past(pd_out[`PD_LASER_BIT])
                    && locate_indicator_request == $past(pd_out[`PD_LOCATE_BIT]);
    endproperty
    a_out_bits: assert property (p_out_bits) else $error("output bits ignored");

    property p_abort;
        @(posedge sys_clk) disable iff (!resetn)
        (state_r == sensor_pkg::ST_SELECT && teach_button && tick &&
         hold_r == 8'(`HOLD_ABORT_TICKS - 1)) |=> state_r == sensor_pkg::ST_IDLE && !factory_restore_req;
    endproperty
    a_abort: assert property (p_abort) else $error("long hold not abandoned");

    property p_disabled;
        @(posedge sys_clk) disable iff (!resetn)
        (!btn_en_r && state_r == sensor_pkg::ST_IDLE) |=> state_r == sensor_pkg::ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled button acted");

    property p_param;
        @(posedge sys_clk) disable iff (!resetn)
        param_req |=> param_ack && param_rdata == $past(param_store_data) ##1 !param_ack || $past(param_req);
    endproperty
    a_param: assert property (p_param) else $error("parameter answer wrong");

endmodule // sensor_process_data_teach
`default_nettype wire

// ==== core/sensor_regs.svh ====
// Purpose: Constants for the sensor teach sequence and process data packing
// Assumes: 125 MHz system clock
// Notes:   Times are kept in their own unit; tick counts derive from them
`ifndef SENSOR_REGS_SVH
`define SENSOR_REGS_SVH

// ---------------------------------------------------------------
// Clock and time base
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      8
`define TICK_US            62500
`define TICK_CYCLES_DEF    ((`TICK_US * 1000) / `CLK_PERIOD_NS)
`define TICKS_PER_S        (1000000 / `TICK_US)

// ---------------------------------------------------------------
// Teach button timing
// ---------------------------------------------------------------
`define HOLD_RESET_US      8000000
`define HOLD_RESET_TICKS   ((`HOLD_RESET_US + `TICK_US - 1) / `TICK_US)
`define HOLD_ABORT_US      12000000
`define HOLD_ABORT_TICKS   ((`HOLD_ABORT_US + `TICK_US - 1) / `TICK_US)
`define SHOW_OK_US         500000
`define SHOW_OK_TICKS      ((`SHOW_OK_US + `TICK_US - 1) / `TICK_US)
`define SHOW_FAIL_US       2000000
`define SHOW_FAIL_TICKS    ((`SHOW_FAIL_US + `TICK_US - 1) / `TICK_US)
`define BTN_TIMEOUT_S_DEF  300

// ---------------------------------------------------------------
// Process data layout
// ---------------------------------------------------------------
`define PD_IN_W            48
`define PD_DIST_LSB        16
`define PD_SCALE_LSB       8
`define PD_ALARM_BIT       3
`define PD_QUALITY_BIT     2
`define PD_SWITCH_BIT      0
`define PD_OUT_W           8
`define PD_LASER_BIT       0
`define PD_LOCATE_BIT      1
`define LASER_RESET_VAL    1'b1

// ---------------------------------------------------------------
// Analog output
// ---------------------------------------------------------------
`define ANALOG_W           12
`define ANALOG_FULL        4095

`endif

// ==== core/sensor_pkg.sv ====
// Purpose: Types shared by the sensor readout design
// Assumes: Constants come from sensor_regs.svh
// Notes:   One-hot teach states
package sensor_pkg;

    // ---------------------------------------------------------------
    // Teach sequence states
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ACTIVE  = 6'h02,
        ST_SELECT  = 6'h04,
        ST_RESTORE = 6'h08,
        ST_OK      = 6'h10,
        ST_FAIL    = 6'h20
    } teach_state_t;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic signed [31:0] distance;
        logic signed [7:0]  scale;
        logic               alarm;
        logic               quality_low;
        logic               switching_channel_one;
    } meas_status_t;

    typedef struct packed {
        logic green;
        logic yellow;
    } led_t;

endpackage

// ==== core/analog_scaler.sv ====
// Purpose: Map a distance onto a 12-bit analog code across a measuring field
// Assumes: Field limits may be swapped to invert the slope
// Notes:   Result clamps at both ends; a zero-width field gives code 0
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs.svh"

module analog_scaler (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    // Field and value
    input  wire logic signed [31:0]          distance,
    input  wire logic signed [31:0]          field_near,
    input  wire logic signed [31:0]          field_far,
    // Code
    output logic         [`ANALOG_W-1:0]     code
);

    logic signed [33:0]          span;
    logic signed [33:0]          off;
    logic signed [47:0]          num;
    logic signed [47:0]          quo;
    logic        [`ANALOG_W-1:0] code_nxt;
    logic        [`ANALOG_W-1:0] code_r;

    // ---------------------------------------------------------------
    // Scaling
    // ---------------------------------------------------------------
    // Divider is wide but only feeds a slow analog stage
    always_comb begin
        span = 34'(field_far) - 34'(field_near);
        off  = 34'(distance) - 34'(field_near);
        num  = 48'(off) * 48'(`ANALOG_FULL);
        quo  = (span == 34'sh0_0000_0000) ? 48'sh0000_0000_0000 : num / 48'(span);
        if (quo < 0) begin
            code_nxt = '0;
        end else if (quo > 48'(`ANALOG_FULL)) begin
            code_nxt = `ANALOG_W'(`ANALOG_FULL);
        end else begin
            code_nxt = quo[`ANALOG_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            code_r <= '0;
        end else begin
            code_r <= code_nxt;
        end
    end

    assign code = code_r;

endmodule // analog_scaler
`default_nettype wire

// ==== testbench/iolink_master_model.sv ====
// Purpose: IO-Link master model, polls process data and parameters
// Assumes: Requests are one- or two-cycle highs, each edge they are high accepted as its own request
// Notes:   Output data is fixed at laser on, locate off unless en, to keep LEDs steady
`timescale 1ns/1ps
`default_nettype none
module iolink_master_model (
    // Clock and control
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        en,
    input  wire logic [31:0] rnd,
    // Requests
    output var logic         pd_poll,
    output var logic [7:0]   pd_out,
    output var logic         param_req,
    output var logic [7:0]   param_index,
    output var logic [31:0]  param_store_data
);
    // ---------------------------------------------------------------
    // Request schedule
    // ---------------------------------------------------------------
    logic [3:0] cnt;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 4'h0;
            pd_poll <= 1'b0;
            param_req <= 1'b0;
        end else begin
            cnt <= cnt + 4'h1;
            pd_poll <= (cnt[2:0] == 3'h0) || (cnt == 4'h1);
            param_req <= (cnt[2:0] == 3'h3) || (cnt == 4'h4);
        end
    end
    // Random output bits only while en, so teach checks see no locate pattern
    always_ff @(posedge sys_clk) begin
        pd_out <= en ? rnd[7:0] : 8'h01;
        param_index <= rnd[15:8];
        param_store_data <= rnd;
    end
endmodule // iolink_master_model
`default_nettype wire

// ==== testbench/sensor_process_data_teach_bench.sv ====
// Purpose: Self-checking bench for teach sequence, process data and analog code
// Assumes: TICK_CYCLES of 4, so one second is 64 cycles
// Notes:   Expected process data noted at each poll, compared when valid shows
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module sensor_process_data_teach_bench;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic sys_clk = 1'b0, resetn = 1'b0, teach_button = 1'b0, en = 1'b1, an_on = 1'b0;
    logic factory_restore_done = 1'b0, factory_restore_fail = 1'b0;
    logic [15:0] btn_timeout_s = 16'h012C;
    sensor_pkg::meas_status_t meas = '0;
    logic [31:0] rnd = 32'h0000_0000, param_store_data, param_rdata;
    logic pd_poll, param_req, factory_restore_req, pd_in_valid, param_ack;
    logic laser_enable, locate_indicator_request;
    logic [7:0] pd_out, param_index, param_store_index;
    logic [`PD_IN_W-1:0] pd_in;
    logic [`ANALOG_W-1:0] analog_code, exp_code;
    sensor_pkg::led_t leds;
    logic [49:0] pdq[$];
    logic [31:0] prq[$];
    int mismatches = 0, n_checks = 0, tg, pd_seen = 0, pa_seen = 0;
    bit sy;
    integer seed = 76;
    always #4 sys_clk = ~sys_clk;
    sensor_process_data_teach #(.TICK_CYCLES(4)) u_dut (.sys_clk, .resetn, .teach_button,
        .btn_timeout_s, .meas, .field_near(-32'sh0000_0800), .field_far(32'sh0000_0800),
        .factory_restore_req, .factory_restore_done, .factory_restore_fail, .pd_poll, .pd_out,
        .pd_in, .pd_in_valid, .param_req, .param_index, .param_store_data, .param_store_index,
        .param_ack, .param_rdata, .leds, .laser_enable, .locate_indicator_request, .analog_code);
    iolink_master_model u_master (.sys_clk, .resetn, .en, .rnd, .pd_poll, .pd_out, .param_req,
        .param_index, .param_store_data);
    // Field runs from -2048 to +2048, full scale 4095 across 4096 units
    function automatic logic [11:0] clampc(input logic signed [31:0] d);
        longint q;
        q = (longint'(d) + 2048) * 4095 / 4096;
        return (q < 0) ? 12'h000 : ((q > 4095) ? 12'hfff : q[11:0]);
    endfunction
    always @(posedge sys_clk) begin : stim
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        meas.distance <= {{19{r[12]}}, r[12:0]};
        meas.scale <= r[20:13];
        meas.alarm <= en & r[21];
        meas.quality_low <= r[22];
        meas.switching_channel_one <= r[23];
        rnd <= r[63:32];
        if (pd_poll) pdq.push_back({meas.distance, meas.scale, 4'h0, meas.alarm,
            meas.quality_low, 1'b0, meas.switching_channel_one, pd_out[1:0]});
        if (param_req) prq.push_back(param_store_data);
        exp_code <= clampc(meas.distance);
    end
    always @(negedge sys_clk) begin : mon
        logic [49:0] e;
        logic [31:0] pe;
        if (resetn && pd_in_valid === 1'b1) begin
            e = pdq.pop_front();
            pd_seen++;
            `CHK("pd_in", e[49:2], pd_in)
            `CHK("laser_enable", e[0], laser_enable)
            `CHK("locate", e[1], locate_indicator_request)
        end
        if (resetn && param_ack === 1'b1) begin
            pa_seen++;
            pe = prq.pop_front();
            `CHK("param_rdata", pe, param_rdata)
        end
        if (param_req) `CHK("store_index", param_index, param_store_index)
        if (an_on) `CHK("analog_code", exp_code, analog_code)
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Counts LED changes; blinking must keep both LEDs in phase
    task automatic watch(input int n);
        sensor_pkg::led_t p;
        repeat (2) @(negedge sys_clk);
        p = leds;
        tg = 0;
        sy = 1'b1;
        repeat (n) begin
            @(negedge sys_clk);
            if (leds !== p) tg++;
            if (leds.green !== leds.yellow) sy = 1'b0;
            p = leds;
        end
    endtask
    task automatic press();
        @(posedge sys_clk);
        teach_button <= 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic teach(input bit fail);
        press();
        `CHK("leds_active", leds, 2'b11)
        cyc(540);
        watch(64);
        `CHK("blink_2hz", (tg >= 3) && (tg <= 5) && sy, 1'b1)
        @(posedge sys_clk);
        teach_button <= 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("restore_req", factory_restore_req, 1'b1)
        @(posedge sys_clk);
        factory_restore_done <= !fail;
        factory_restore_fail <= fail;
        @(posedge sys_clk);
        factory_restore_done <= 1'b0;
        factory_restore_fail <= 1'b0;
        if (fail) begin
            watch(64);
            `CHK("blink_8hz", (tg >= 14) && (tg <= 18) && sy, 1'b1)
            cyc(100);
        end else begin
            repeat (2) @(negedge sys_clk);
            `CHK("leds_ok", leds, 2'b11)
            cyc(40);
        end
        @(negedge sys_clk);
        `CHK("back_normal", {factory_restore_req, leds}, 3'b010)
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Short run; the limit is several times the expected length
    initial begin
        #200_000;
        mismatches++;
        test_done();
    end
    initial begin
        cyc(10);
        resetn <= 1'b1;
        cyc(2);
        an_on <= 1'b1;
        cyc(200);
        en <= 1'b0;
        cyc(20);
        `CHK("pd_count", (pd_seen > 10) && (pa_seen > 10) && (pdq.size() < 2), 1'b1)
        $display("test process data done");
        teach(1'b0);
        $display("test factory reset ok done");
        teach(1'b1);
        $display("test factory reset fail done");
        press();
        cyc(800);
        @(negedge sys_clk);
        `CHK("abort_held", {factory_restore_req, leds}, 3'b010)
        @(posedge sys_clk);
        teach_button <= 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK("abort_hold", {factory_restore_req, leds}, 3'b010)
        $display("test long hold done");
        @(posedge sys_clk);
        an_on <= 1'b0;
        resetn <= 1'b0;
        btn_timeout_s <= 16'h0001;
        cyc(3);
        pdq.delete();
        prq.delete();
        resetn <= 1'b1;
        cyc(80);
        press();
        `CHK("button_timeout", leds, 2'b10)
        $display("test button timeout done");
        test_done();
    end
endmodule // sensor_process_data_teach_bench
`default_nettype wire
